// file: dv/dit_asserts.sv
// Port checks for the dual interval timer
`timescale 1ns/1ns
`default_nettype none
module dit_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic filter_strap,
    input wire dit_pkg::dit_apb_req_t apb_req,
    input wire dit_pkg::dit_apb_rsp_t apb_rsp,
    input wire dit_pkg::dit_pin_in_t [1:0] pins_in,
    input wire dit_pkg::dit_pin_out_t [1:0] pins_out
);
    import dit_pkg::*;
    logic setup;
    logic wr0;
    logic bad;
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr0 = apb_req.psel && apb_req.pwrite && apb_req.paddr[7:5] == 3'h0;
    assign bad = apb_req.paddr[1:0] != 2'h0 || apb_req.paddr[7:6] != 2'h0
        || apb_req.paddr[4:2] > 3'h4;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_ready_next: assert property (setup |=> apb_rsp.pready)
        else $error("pready missing after setup");
    chk_ready_cause: assert property (apb_rsp.pready |-> $past(setup))
        else $error("pready without setup");
    chk_unmapped_err: assert property (apb_rsp.pready && bad |->
        apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (apb_rsp.pready && !bad |-> !apb_rsp.pslverr)
        else $error("mapped access refused");
    chk_upper_zero: assert property (apb_rsp.pready && !apb_req.pwrite |->
        apb_rsp.prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_uf_pulse: assert property (pins_out[0].underflow |=> !pins_out[0].underflow)
        else $error("underflow longer than one cycle");
    chk_uf_running: assert property (pins_out[1].underflow |->
        $past(pins_out[1].run_state))
        else $error("underflow while stopped");
    chk_run_cause: assert property (!$stable(pins_out[0].run_state) |->
        $past(wr0) || $past(wr0, 2))
        else $error("run output moved without write");
    chk_gate_cause: assert property (!$stable(pins_out[0].gate_enable) |->
        $past(wr0) || $past(wr0, 2))
        else $error("gate output moved without write");
    cover property (pins_out[0].underflow);
    cover property (pins_out[1].underflow);
    cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule // dit_asserts
`default_nettype wire

// file: dv/dit_pins_model.sv
// External clock and gate source for both timers
`timescale 1ns/1ns
`default_nettype none
module dit_pins_model (
    input wire logic clk,
    output var dit_pkg::dit_pin_in_t [1:0] pins
);
    import dit_pkg::*;
    initial pins = '0;
    // Gate level, then settle past sync and filter
    task automatic gate(input int t, input logic v);
        @(posedge clk);
        pins[t].ext_gate <= v;
        repeat (12) @(posedge clk);
    endtask
    // Clock bursts, clock idle low between them, period above 20 us
    task automatic burst(input int t, input int n);
        repeat (n) begin
            @(posedge clk);
            pins[t].ext_clk <= 1'b1;
            repeat (250) @(posedge clk);
            pins[t].ext_clk <= 1'b0;
            repeat (250) @(posedge clk);
        end
        repeat (13) @(posedge clk);
    endtask
endmodule // dit_pins_model
`default_nettype wire

// file: dv/dit_tb.sv
// Self-checking bench for the dual interval timer
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import dit_pkg::*;
    localparam int US = 25;
    logic clk;
    logic rstn;
    logic filter_strap;
    dit_apb_req_t apb_req;
    dit_apb_rsp_t apb_rsp;
    dit_pin_in_t [1:0] pins_in;
    dit_pin_out_t [1:0] pins_out;
    int failures;
    int cmp_count;
    int cyc = 0;
    logic [31:0] rd;
    logic err;
    dit_top #(.US_CYC(5'h19), .FILT_CYC(8'h04)) uut (.clk(clk), .rstn(rstn),
        .filter_strap(filter_strap), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .pins_in(pins_in), .pins_out(pins_out));
    dit_pins_model far (.clk(clk), .pins(pins_in));
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 20);
        chk("pready", 32'h1, {31'h0, apb_rsp.pready});
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(negedge clk);
    endtask
    task automatic wait_uf(input int t);
        int c;
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (pins_out[t].underflow !== 1'b1 && c < 1400);
        chk("underflow seen", 32'h1, {31'h0, pins_out[t].underflow});
    endtask
    task automatic setup_tmr(input logic [7:0] b, input logic [31:0] m, input logic [31:0] n);
        apb(1'b1, b, 32'h0);
        apb(1'b1, b + 8'h04, m);
        apb(1'b1, b + 8'h08, n);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, 8'h08, 32'h0);
        chk("count reset", 32'h0, rd);
        apb(1'b0, 8'h2C, 32'h0);
        chk("reload reset", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("status strap", 32'h2, rd);
        apb(1'b0, 8'h14, 32'h0);
        chk("index err", 32'h1, {31'h0, err});
        apb(1'b1, 8'h41, 32'h5);
        chk("align err", 32'h1, {31'h0, err});
    endtask
    task automatic t_bases();
        int us[4] = '{1, 5, 25, 50};
        int t1;
        for (int k = 0; k < 4; k++) begin
            setup_tmr(8'h20, 32'h10 | k, 32'h0);
            apb(1'b1, 8'h2C, 32'h0);
            apb(1'b1, 8'h20, 32'h1);
            chk("run out", 32'h1, {31'h0, pins_out[1].run_state});
            wait_uf(1);
            t1 = cyc;
            wait_uf(1);
            chk("base period", US * us[k], cyc - t1);
        end
        apb(1'b1, 8'h20, 32'h0);
    endtask
    task automatic t_periodic();
        int t1;
        setup_tmr(8'h00, 32'h10, 32'h2);
        apb(1'b1, 8'h0C, 32'h3);
        apb(1'b1, 8'h00, 32'h1);
        wait_uf(0);
        t1 = cyc;
        apb(1'b0, 8'h08, 32'h0);
        chk("reloaded", 32'h3, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("flag set", 32'h3, rd);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk("flag clear", 32'h2, rd);
        wait_uf(0);
        chk("periodic span", 4 * US, cyc - t1);
        apb(1'b1, 8'h08, 32'h9);
        apb(1'b0, 8'h08, 32'h0);
        chk("write ignored", 32'h3, rd);
        apb(1'b0, 8'h28, 32'h0);
        chk("other timer", 32'h0, rd);
        apb(1'b1, 8'h00, 32'h0);
        chk("run off", 32'h0, {31'h0, pins_out[0].run_state});
    endtask
    task automatic t_aperiodic();
        setup_tmr(8'h00, 32'h01, 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        wait_uf(0);
        apb(1'b0, 8'h08, 32'h0);
        chk("wrap", 32'h0000_FFFF, rd);
        apb(1'b1, 8'h00, 32'h0);
    endtask
    task automatic t_external();
        setup_tmr(8'h00, 32'h24, 32'hA);
        apb(1'b1, 8'h00, 32'h1);
        chk("gate out", 32'h1, {31'h0, pins_out[0].gate_enable});
        far.gate(0, 1'b0);
        far.burst(0, 3);
        apb(1'b0, 8'h08, 32'h0);
        chk("gated off", 32'hA, rd);
        far.gate(0, 1'b1);
        far.burst(0, 3);
        apb(1'b0, 8'h08, 32'h0);
        chk("ext ticks", 32'h7, rd);
        apb(1'b1, 8'h00, 32'h0);
    endtask
    task automatic t_strap();
        @(posedge clk);
        filter_strap <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, 8'h10, 32'h0);
        chk("status no filter", 32'h0, rd);
        chk("run after reset", 32'h0, {31'h0, pins_out[0].run_state});
        setup_tmr(8'h20, 32'h04, 32'h5);
        apb(1'b1, 8'h20, 32'h1);
        far.burst(1, 2);
        apb(1'b0, 8'h28, 32'h0);
        chk("raw ext ticks", 32'h3, rd);
        apb(1'b1, 8'h20, 32'h0);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        failures++;
        test_done();
    end
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        filter_strap = 1'b1;
        apb_req = '0;
        failures = 0;
        cmp_count = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_bases();
        t_periodic();
        t_aperiodic();
        t_external();
        t_strap();
        test_done();
    end
endmodule // testbench
bind dit_top dit_asserts u_chk (.clk(clk), .rstn(rstn), .filter_strap(filter_strap),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .pins_in(pins_in), .pins_out(pins_out));
`default_nettype wire

// file: src/dit_map.svh
// Register offsets, field positions, reset values and timing counts of the interval timer
`ifndef DIT_MAP_SVH
`define DIT_MAP_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DIT_TIMER_STRIDE 8'h20
`define DIT_TIMER_IDX_BIT 5
`define DIT_REG_CTRL 3'h0
`define DIT_REG_MODE 3'h1
`define DIT_REG_COUNT 3'h2
`define DIT_REG_RELOAD 3'h3
`define DIT_REG_STATUS 3'h4
`define DIT_OFF_CTRL 8'h00
`define DIT_OFF_MODE 8'h04
`define DIT_OFF_COUNT 8'h08
`define DIT_OFF_RELOAD 8'h0C
`define DIT_OFF_STATUS 8'h10
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define DIT_CTRL_RUN_BIT 0
`define DIT_MODE_TB_LSB 0
`define DIT_MODE_PER_BIT 4
`define DIT_MODE_GATE_BIT 5
`define DIT_STAT_FLAG_BIT 0
`define DIT_STAT_FILT_BIT 1
`define DIT_TB_EXT 3'h4
// ----------------------------------------------------------------
// Reset values and count wrap value
// ----------------------------------------------------------------
`define DIT_RST_COUNT 16'h0000
`define DIT_RST_RELOAD 16'h0000
`define DIT_RST_TB 3'h0
`define DIT_COUNT_WRAP 16'hFFFF
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DIT_CLK_KHZ 25000
`define DIT_TB0_US 1
`define DIT_TB1_US 5
`define DIT_TB2_US 25
`define DIT_TB3_US 50
`define DIT_FILT_US 5
`define DIT_US_CYC ((`DIT_TB0_US * `DIT_CLK_KHZ) / 1000)
`define DIT_FILT_CYC ((`DIT_FILT_US * `DIT_CLK_KHZ + 999) / 1000)
`endif

// file: src/dit_pkg.sv
// Types of the dual interval timer
`default_nettype none
package dit_pkg;

typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
} dit_apb_req_t;

typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
} dit_apb_rsp_t;

typedef struct packed {
    logic ext_clk;
    logic ext_gate;
} dit_pin_in_t;

typedef struct packed {
    logic run_state;
    logic gate_enable;
    logic underflow;
} dit_pin_out_t;

typedef struct packed {
    logic ok;
    logic idx;
    logic [2:0] sel;
} dit_dec_t;

typedef struct packed {
    logic run;
    logic [2:0] tb;
    logic periodic;
    logic gate_en;
    logic [15:0] count;
    logic [15:0] reload;
    logic flag;
    logic uf;
    logic [1:0] clk_s;
    logic [1:0] gate_s;
    logic clk_f;
    logic gate_f;
    logic clk_prev;
    logic [7:0] clk_fc;
    logic [7:0] gate_fc;
} dit_timer_t;

typedef struct packed {
    dit_timer_t [1:0] tmr;
    logic [4:0] us_cnt;
    logic [2:0] c5;
    logic [4:0] c25;
    logic [5:0] c50;
    logic filt_on;
    logic strap_done;
    dit_apb_rsp_t rsp;
} dit_state_t;

endpackage

`default_nettype wire

// file: src/dit_top.sv
// Dual 16-bit interval timer with APB register access
// Notes on behaviour
// - Two timers, each with its own 16-bit count.
// - Each timer works as interval, pulse or pulse-duration counter with end event.
// - Each timer has run and gate-enable outputs, clock and gate inputs.
// - Each timer has its own address window, controlled independently.
// - Reading the count never disturbs counting.
// - Mode selects one of four internal time bases or the external clock.
// - Running timer decrements once per selected time base tick.
// - Internal time bases tick every 1, 5, 25 or 50 microseconds.
// - Input filter chosen by a strap, not by software.
// - Mode holds a software-set gate enable bit and time base choice.
// - Each timer has a 16-bit reload register, freely writable.
// - Periodic mode reloads at underflow and raises an event.
// - Aperiodic mode raises an event at underflow and wraps without reload.
// - With gate enabled, the external gate starts and stops counting.
// - Each command moves one word between processor and timer.
`timescale 1ns/1ns
`default_nettype none
`include "dit_map.svh"

module dit_top #(
    parameter logic [4:0] US_CYC = 5'(`DIT_US_CYC),
    parameter logic [7:0] FILT_CYC = 8'(`DIT_FILT_CYC)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic filter_strap,
    input wire dit_pkg::dit_apb_req_t apb_req,
    output dit_pkg::dit_apb_rsp_t apb_rsp,
    input wire dit_pkg::dit_pin_in_t [1:0] pins_in,
    output dit_pkg::dit_pin_out_t [1:0] pins_out
);
    import dit_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic dit_dec_t dit_decode(input logic [7:0] addr);
        dit_dec_t d;
        d.idx = addr[`DIT_TIMER_IDX_BIT];
        d.sel = addr[4:2];
        d.ok = (addr[1:0] == 2'b00) && (addr[7:6] == 2'b00) && (addr[4:2] <= `DIT_REG_STATUS);
        return d;
    endfunction

    // Filter: new level only after it has held FILT_CYC cycles
    function automatic logic [8:0] dit_filter(input logic raw, input logic f,
                                               input logic [7:0] fc, input logic on);
        logic [8:0] r;
        r = {f, 8'h00};
        if (!on) begin
            r = {raw, 8'h00};
        end else if (raw != f) begin
            if (fc == FILT_CYC - 8'h01) begin
                r = {raw, 8'h00};
            end else begin
                r = {f, fc + 8'h01};
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dit_state_t st;
    dit_state_t next_st;
    dit_dec_t dec;
    dit_timer_t t;
    dit_timer_t nt;
    logic [3:0] tb_tick;
    logic tick1;
    logic setup;
    logic access;
    logic wr;
    logic tick;
    logic gate_ok;
    logic clr;
    logic [8:0] fres;

    always_comb begin
        next_st = st;
        t = st.tmr[0];
        nt = st.tmr[0];
        tick = 1'b0;
        gate_ok = 1'b0;
        clr = 1'b0;
        wr = 1'b0;
        fres = '0;
        // Shared time base prescaler
        tick1 = (st.us_cnt == US_CYC - 5'd1);
        next_st.us_cnt = tick1 ? 5'd0 : st.us_cnt + 5'd1;
        if (tick1) begin
            next_st.c5 = (st.c5 == 3'(`DIT_TB1_US - 1)) ? 3'd0 : st.c5 + 3'd1;
            next_st.c25 = (st.c25 == 5'(`DIT_TB2_US - 1)) ? 5'd0 : st.c25 + 5'd1;
            next_st.c50 = (st.c50 == 6'(`DIT_TB3_US - 1)) ? 6'd0 : st.c50 + 6'd1;
        end
        tb_tick[0] = tick1;
        tb_tick[1] = tick1 && (st.c5 == 3'(`DIT_TB1_US - 1));
        tb_tick[2] = tick1 && (st.c25 == 5'(`DIT_TB2_US - 1));
        tb_tick[3] = tick1 && (st.c50 == 6'(`DIT_TB3_US - 1));
        // Strap caught once after reset release
        if (!st.strap_done) begin
            next_st.filt_on = filter_strap;
            next_st.strap_done = 1'b1;
        end
        // APB: answer prepared in setup, given in access
        dec = dit_decode(apb_req.paddr);
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && st.rsp.pready;
        next_st.rsp.pready = setup;
        next_st.rsp.pslverr = setup && !dec.ok;
        next_st.rsp.prdata = 32'h0000_0000;
        if (setup && dec.ok && !apb_req.pwrite) begin
            t = st.tmr[dec.idx];
            case (dec.sel)
                `DIT_REG_CTRL: next_st.rsp.prdata[`DIT_CTRL_RUN_BIT] = t.run;
                `DIT_REG_MODE: begin
                    next_st.rsp.prdata[`DIT_MODE_TB_LSB +: 3] = t.tb;
                    next_st.rsp.prdata[`DIT_MODE_PER_BIT] = t.periodic;
                    next_st.rsp.prdata[`DIT_MODE_GATE_BIT] = t.gate_en;
                end
                `DIT_REG_COUNT: next_st.rsp.prdata[15:0] = t.count;
                `DIT_REG_RELOAD: next_st.rsp.prdata[15:0] = t.reload;
                `DIT_REG_STATUS: begin
                    next_st.rsp.prdata[`DIT_STAT_FLAG_BIT] = t.flag;
                    next_st.rsp.prdata[`DIT_STAT_FILT_BIT] = st.filt_on;
                end
                default: next_st.rsp.prdata = 32'h0000_0000;
            endcase
        end
        // Timers
        for (int i = 0; i < 2; i++) begin
            t = st.tmr[i];
            nt = st.tmr[i];
            // Two-stage synchronisers, then filter and edge detect
            nt.clk_s = {t.clk_s[0], pins_in[i].ext_clk};
            nt.gate_s = {t.gate_s[0], pins_in[i].ext_gate};
            fres = dit_filter(t.clk_s[1], t.clk_f, t.clk_fc, st.filt_on);
            nt.clk_f = fres[8];
            nt.clk_fc = fres[7:0];
            fres = dit_filter(t.gate_s[1], t.gate_f, t.gate_fc, st.filt_on);
            nt.gate_f = fres[8];
            nt.gate_fc = fres[7:0];
            nt.clk_prev = t.clk_f;
            // Tick source selection
            if (t.tb < `DIT_TB_EXT) begin
                tick = tb_tick[t.tb[1:0]];
            end else begin
                tick = t.clk_f && !t.clk_prev;
            end
            gate_ok = !t.gate_en || t.gate_f;
            nt.uf = 1'b0;
            if (t.run && gate_ok && tick) begin
                if (t.count == 16'h0000) begin
                    nt.uf = 1'b1;
                    if (t.periodic) begin
                        nt.count = t.reload;
                    end else begin
                        nt.count = `DIT_COUNT_WRAP;
                    end
                end else begin
                    nt.count = t.count - 16'h0001;
                end
            end
            // Register writes
            wr = access && apb_req.pwrite && dec.ok && (dec.idx == i[0]);
            if (wr) begin
                case (dec.sel)
                    `DIT_REG_CTRL: nt.run = apb_req.pwdata[`DIT_CTRL_RUN_BIT];
                    `DIT_REG_MODE: begin
                        if (!t.run) begin
                            nt.tb = apb_req.pwdata[`DIT_MODE_TB_LSB +: 3];
                            nt.periodic = apb_req.pwdata[`DIT_MODE_PER_BIT];
                            nt.gate_en = apb_req.pwdata[`DIT_MODE_GATE_BIT];
                        end
                    end
                    `DIT_REG_COUNT: begin
                        if (!t.run) begin
                            nt.count = apb_req.pwdata[15:0];
                        end
                    end
                    `DIT_REG_RELOAD: nt.reload = apb_req.pwdata[15:0];
                    `DIT_REG_STATUS: clr = apb_req.pwdata[`DIT_STAT_FLAG_BIT];
                    default: clr = 1'b0;
                endcase
            end
            // Event flag, set wins over clear
            nt.flag = (t.flag && !clr) || nt.uf;
            next_st.tmr[i] = nt;
            clr = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            for (int i = 0; i < 2; i++) begin
                st.tmr[i].tb <= `DIT_RST_TB;
                st.tmr[i].count <= `DIT_RST_COUNT;
                st.tmr[i].reload <= `DIT_RST_RELOAD;
            end
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign apb_rsp = st.rsp;
    generate
        for (genvar g = 0; g < 2; g++) begin : g_pins
            assign pins_out[g].run_state = st.tmr[g].run;
            assign pins_out[g].gate_enable = st.tmr[g].gate_en;
            assign pins_out[g].underflow = st.tmr[g].uf;
        end
    endgenerate

endmodule // dit_top

`default_nettype wire
